// *** hdl/mcuip_pkg.sv ***
// Package: register map, field layout and source tables of the controller
package mcuip_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] ENA_IDX = 8'hA8;
  localparam logic [7:0] PRL_IDX = 8'hA9;
  localparam logic [7:0] ENB_IDX = 8'hB8;
  localparam logic [7:0] PRH_IDX = 8'hB9;
  localparam logic [7:0] FLG_IDX = 8'hC0;

  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [7:0] ENA_MASK = 8'hBF;
  localparam logic [7:0] ENB_MASK = 8'hB3;
  localparam logic [7:0] PRI_MASK = 8'h3F;
  localparam logic [7:0] FLG_MASK = 8'hF3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GLB_BIT   = 7;
  localparam int T2_BIT    = 5;
  localparam int SER0_BIT  = 4;
  localparam int T1_BIT    = 3;
  localparam int EXT1_BIT  = 2;
  localparam int T0_BIT    = 1;
  localparam int EXT0_BIT  = 0;
  localparam int T2RL_BIT  = 7;
  localparam int T2OV_BIT  = 6;
  localparam int I2C_BIT   = 5;
  localparam int LVI_BIT   = 4;
  localparam int SPI_BIT   = 1;
  localparam int PWM_BIT   = 0;

  // ****************************************
  // Sources in polling order
  // ****************************************
  localparam int NSRC   = 10;
  localparam int S_EXT0 = 0;
  localparam int S_PWM  = 1;
  localparam int S_T0   = 2;
  localparam int S_SPI  = 3;
  localparam int S_EXT1 = 4;
  localparam int S_T1   = 5;
  localparam int S_SER0 = 6;
  localparam int S_LVI  = 7;
  localparam int S_T2   = 8;
  localparam int S_I2C  = 9;

  localparam logic [9:0][2:0] SRC_GROUP = {
    3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
  localparam logic [9:0][15:0] SRC_VECTOR = {
    16'h006B, 16'h002B, 16'h0063, 16'h0023, 16'h001B,
    16'h0013, 16'h004B, 16'h000B, 16'h0043, 16'h0003};

  localparam int DETECT_CYC = 1;

  typedef struct packed {
    logic        t2_reload;
    logic        t2_ovf;
    logic        i2c;
    logic        low_voltage_detect;
    logic        spi;
    logic        pwm;
  } mcuip_evt_t;

  typedef struct packed {
    logic        req;
    logic [1:0]  level;
    logic [15:0] vector;
  } mcuip_core_t;

endpackage : mcuip_pkg

// *** hdl/mcuip_top.sv ***
// Interrupt enable, request flag and priority controller with AHB-Lite slave
// How it works
// RQ1 - Global gate zero blocks every request
// RQ2 - Enable A bit 5 gates timer 2
// RQ3 - Enable A bit 4 gates serial 0
// RQ4 - Enable A bit 2 gates external 1
// RQ5 - Enable A bits 1, 3 gate timers
// RQ6 - Enable A bit 0 gates external 0
// RQ7 - Enable B bit 7 gates timer 2 reload
// RQ8 - Enable B bits 5, 4, 1 gate others
// RQ9 - Enable B bit 0 gates PWM
// RQ10 - Request flag register bit layout
// RQ11 - Flags cleared only by software
// RQ12 - Ten sources form six priority groups
// RQ13 - High and low bits form level
// RQ14 - Equal level ties resolved by polling
// RQ15 - Fixed polling order, external 0 first
// RQ16 - Unused bits read zero, ignore writes
// RQ17 - Flags set regardless of enables
// RQ18 - Each source supplies fixed vector
// RQ19 - Only strictly higher level preempts
// RQ20 - Request detected within one cycle
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mcuip_top (
  input  wire  logic                  clk,
  input  wire  logic                  rst_b,
  input  wire  logic                  hsel,
  input  wire  logic [31:0]           haddr,
  input  wire  logic [1:0]            htrans,
  input  wire  logic                  hwrite,
  input  wire  logic [2:0]            hsize,
  input  wire  logic [31:0]           hwdata,
  input  wire  logic                  hready,
  output var   logic [31:0]           hrdata,
  output var   logic                  hreadyout,
  output var   logic                  hresp,
  input  wire  logic [4:0]            src_level_in,
  input  wire  mcuip_pkg::mcuip_evt_t src_evt,
  input  wire  logic                  core_ack,
  input  wire  logic                  core_reti,
  output var   mcuip_pkg::mcuip_core_t core_out,
  output var   logic [9:0]            ack_src
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic [7:0] ena_r;
  logic [7:0] enb_r;
  logic [7:0] prl_r;
  logic [7:0] prh_r;
  logic [7:0] flg_r;
  logic [7:0] flg_nxt;
  logic [7:0] rd_val;
  logic [7:0] wr_idx_r;
  logic       wr_pend_r;
  logic       take;
  logic       mapped;
  logic [7:0] idx;

  assign idx    = haddr[9:2];
  assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign take   = hsel && htrans[1] && hready;
  // Zero wait state: every transfer completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    rd_val = 8'h00;
    if (mapped) begin
      case (idx)
        mcuip_pkg::ENA_IDX: rd_val = ena_r;
        mcuip_pkg::ENB_IDX: rd_val = enb_r;
        mcuip_pkg::PRL_IDX: rd_val = prl_r;
        mcuip_pkg::PRH_IDX: rd_val = prh_r;
        mcuip_pkg::FLG_IDX: rd_val = flg_r;
        default:            rd_val = 8'h00;
      endcase
    end
  end

  // Read data latched at the address phase, so it stands as a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= {24'h0, rd_val};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite && mapped;
      wr_idx_r  <= idx;
    end
  end

  // ****************************************
  // Enable and priority registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ena_r <= mcuip_pkg::REG_RST;
      enb_r <= mcuip_pkg::REG_RST;
      prl_r <= mcuip_pkg::REG_RST;
      prh_r <= mcuip_pkg::REG_RST;
    end else if (wr_pend_r) begin
      case (wr_idx_r)
        mcuip_pkg::ENA_IDX: ena_r <= hwdata[7:0] & mcuip_pkg::ENA_MASK; // RQ16
        mcuip_pkg::ENB_IDX: enb_r <= hwdata[7:0] & mcuip_pkg::ENB_MASK; // RQ16
        mcuip_pkg::PRL_IDX: prl_r <= hwdata[7:0] & mcuip_pkg::PRI_MASK; // RQ16
        mcuip_pkg::PRH_IDX: prh_r <= hwdata[7:0] & mcuip_pkg::PRI_MASK; // RQ16
        default:            ena_r <= ena_r;
      endcase
    end
  end

  // ****************************************
  // Request flags
  // ****************************************
  logic [7:0] evt_vec;
  logic       wr_flg;

  always_comb begin
    evt_vec = 8'h00;
    evt_vec[mcuip_pkg::T2RL_BIT] = src_evt.t2_reload; // RQ10
    evt_vec[mcuip_pkg::T2OV_BIT] = src_evt.t2_ovf; // RQ10
    evt_vec[mcuip_pkg::I2C_BIT]  = src_evt.i2c; // RQ10
    evt_vec[mcuip_pkg::LVI_BIT]  = src_evt.low_voltage_detect; // RQ10
    evt_vec[mcuip_pkg::SPI_BIT]  = src_evt.spi; // RQ10
    evt_vec[mcuip_pkg::PWM_BIT]  = src_evt.pwm; // RQ10
  end

  assign wr_flg = wr_pend_r && (wr_idx_r == mcuip_pkg::FLG_IDX);
  // Set beats a clearing write in the same cycle; no hardware clear
  assign flg_nxt = ((wr_flg ? hwdata[7:0] : flg_r) | evt_vec)
                   & mcuip_pkg::FLG_MASK; // RQ11 RQ17

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flg_r <= mcuip_pkg::REG_RST;
    end else begin
      flg_r <= flg_nxt;
    end
  end

  // ****************************************
  // Source gating
  // ****************************************
  logic [9:0] src_en;
  logic       glb;

  assign glb = ena_r[mcuip_pkg::GLB_BIT];

  always_comb begin
    src_en = 10'h000;
    src_en[mcuip_pkg::S_EXT0] = src_level_in[0]
                                & ena_r[mcuip_pkg::EXT0_BIT]; // RQ6
    src_en[mcuip_pkg::S_T0]   = src_level_in[1]
                                & ena_r[mcuip_pkg::T0_BIT]; // RQ5
    src_en[mcuip_pkg::S_EXT1] = src_level_in[2]
                                & ena_r[mcuip_pkg::EXT1_BIT]; // RQ4
    src_en[mcuip_pkg::S_T1]   = src_level_in[3]
                                & ena_r[mcuip_pkg::T1_BIT]; // RQ5
    src_en[mcuip_pkg::S_SER0] = src_level_in[4]
                                & ena_r[mcuip_pkg::SER0_BIT]; // RQ3
    src_en[mcuip_pkg::S_T2]   = ena_r[mcuip_pkg::T2_BIT]
      & (flg_r[mcuip_pkg::T2OV_BIT]
         | (flg_r[mcuip_pkg::T2RL_BIT]
            & enb_r[mcuip_pkg::T2RL_BIT])); // RQ2 RQ7
    src_en[mcuip_pkg::S_I2C]  = flg_r[mcuip_pkg::I2C_BIT]
                                & enb_r[mcuip_pkg::I2C_BIT]; // RQ8
    src_en[mcuip_pkg::S_LVI]  = flg_r[mcuip_pkg::LVI_BIT]
                                & enb_r[mcuip_pkg::LVI_BIT]; // RQ8
    src_en[mcuip_pkg::S_SPI]  = flg_r[mcuip_pkg::SPI_BIT]
                                & enb_r[mcuip_pkg::SPI_BIT]; // RQ8
    src_en[mcuip_pkg::S_PWM]  = flg_r[mcuip_pkg::PWM_BIT]
                                & enb_r[mcuip_pkg::PWM_BIT]; // RQ9
    src_en = glb ? src_en : 10'h000; // RQ1
  end

  // ****************************************
  // Priority levels and polling
  // ****************************************
  logic [9:0][1:0] src_lvl;

  for (genvar g = 0; g < mcuip_pkg::NSRC; g++) begin : g_lvl
    assign src_lvl[g] = {prh_r[mcuip_pkg::SRC_GROUP[g]],
                         prl_r[mcuip_pkg::SRC_GROUP[g]]}; // RQ12 RQ13
  end

  logic       found;
  logic [1:0] best_lvl;
  logic [3:0] best_idx;

  // Ascending scan with strict compare keeps the earliest polled winner
  always_comb begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_idx = 4'h0;
    for (int i = 0; i < mcuip_pkg::NSRC; i++) begin
      if (src_en[i] && (!found || src_lvl[i] > best_lvl)) begin
        found    = 1'b1;
        best_lvl = src_lvl[i];
        best_idx = 4'(i); // RQ14 RQ15
      end
    end
  end

  // ****************************************
  // In-service levels and core request
  // ****************************************
  logic [3:0] insvc_r;
  logic [3:0] insvc_nxt;
  logic       busy;
  logic [1:0] cur_lvl;
  logic       allow;
  logic [3:0] win_idx_r;

  always_comb begin
    busy    = |insvc_r;
    cur_lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (insvc_r[i]) begin
        cur_lvl = 2'(i);
      end
    end
  end

  assign allow = found && (!busy || best_lvl > cur_lvl); // RQ19

  always_comb begin
    insvc_nxt = insvc_r;
    if (core_reti && busy) begin
      insvc_nxt[cur_lvl] = 1'b0;
    end
    if (core_ack && core_out.req) begin
      insvc_nxt[core_out.level] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      insvc_r <= 4'h0;
    end else begin
      insvc_r <= insvc_nxt;
    end
  end

  // One cycle to sample the winner; the core adds its long call
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_out  <= '0;
      win_idx_r <= 4'h0;
    end else begin
      core_out.req    <= allow; // RQ20
      core_out.level  <= allow ? best_lvl : 2'h0;
      core_out.vector <= allow ? mcuip_pkg::SRC_VECTOR[best_idx]
                               : 16'h0000; // RQ18
      win_idx_r       <= best_idx;
    end
  end

  // Tells the peripheral which source was taken; flags stay set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_src <= 10'h000;
    end else begin
      ack_src <= (core_ack && core_out.req) ? (10'h001 << win_idx_r)
                                             : 10'h000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  localparam int DET = mcuip_pkg::DETECT_CYC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Top level, or all levels zero, so external 0 wins either way
  sequence s_ext0_ready;
    glb && ena_r[mcuip_pkg::EXT0_BIT] && src_level_in[0] && !busy
      && ((prh_r[0] && prl_r[0]) || ((prh_r | prl_r) == 8'h00));
  endsequence

  sequence s_ext0_served;
    core_out.req && core_out.vector == 16'h0003;
  endsequence

  a_glb_gate_off: assert property (!glb |=> !core_out.req) // RQ1
    else $error("request with global gate clear");
  a_t2_gate_off: assert property (!ena_r[mcuip_pkg::T2_BIT]
    |=> !(core_out.req && core_out.vector == 16'h002B)) // RQ2
    else $error("timer 2 request while gated");
  a_ser0_gate_off: assert property (!ena_r[mcuip_pkg::SER0_BIT]
    |=> !(core_out.req && core_out.vector == 16'h0023)) // RQ3
    else $error("serial 0 request while gated");
  a_ext1_gate_off: assert property (!ena_r[mcuip_pkg::EXT1_BIT]
    |=> !(core_out.req && core_out.vector == 16'h0013)) // RQ4
    else $error("external 1 request while gated");
  a_t2_reload_gate: assert property (!enb_r[mcuip_pkg::T2RL_BIT]
    && !flg_r[mcuip_pkg::T2OV_BIT]
    |=> !(core_out.req && core_out.vector == 16'h002B)) // RQ7
    else $error("timer 2 reload request while gated");
  a_pwm_gate_off: assert property (!enb_r[mcuip_pkg::PWM_BIT]
    |=> !(core_out.req && core_out.vector == 16'h0043)) // RQ9
    else $error("PWM request while gated");
  a_flag_set_evt: assert property (src_evt.pwm
    |=> flg_r[mcuip_pkg::PWM_BIT]) // RQ17
    else $error("PWM event did not set flag");
  a_flag_hold: assert property (flg_r[mcuip_pkg::T2OV_BIT] && !wr_flg
    |=> flg_r[mcuip_pkg::T2OV_BIT]) // RQ11
    else $error("timer 2 overflow flag lost without write");
  a_rsvd_zero: assert property (take && !hwrite
    |=> hrdata[31:8] == 24'h0 && (!(hrdata[3] || hrdata[2])
        || $past(idx) != mcuip_pkg::FLG_IDX)) // RQ16
    else $error("reserved bits read nonzero");
  a_tie_poll: assert property (s_ext0_ready ##0 (src_en[mcuip_pkg::S_PWM])
    |-> ##DET s_ext0_served) // RQ15
    else $error("polling order broken on tie");
  a_ext0_detect: assert property (s_ext0_ready |-> ##[1:DET]
    s_ext0_served) // RQ20
    else $error("top request not presented in time");
  a_preempt_lvl: assert property (busy && !core_reti && !core_ack
    |=> !core_out.req || core_out.level > $past(cur_lvl)) // RQ19
    else $error("request without higher level");
  a_level_map: assert property (allow |=> core_out.level
    == $past(best_lvl) && core_out.vector
    == mcuip_pkg::SRC_VECTOR[$past(best_idx)]) // RQ13 RQ18
    else $error("level or vector mismatch");

endmodule : mcuip_top

`default_nettype wire

// *** testbench/mcuip_core_model.sv ***
// Core-side model: takes offered requests and returns from service
`timescale 1ns/10ps
`default_nettype none

module mcuip_core_model (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire mcuip_pkg::mcuip_core_t core_in,
  input  wire logic                   take,
  input  wire logic [3:0]             lag,
  input  wire logic                   ret_go,
  output var  logic                   core_ack,
  output var  logic                   core_reti,
  output var  logic [15:0]            taken_vec
);
  // ****************************************
  // Acknowledge after a programmable lag
  // ****************************************
  logic [2:0] cool_r;
  logic [3:0] wait_r;

  // Cool-down stops the stale request of the ack cycle being taken twice
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      cool_r   <= 3'h0;
      wait_r   <= 4'h0;
    end else begin
      core_ack <= 1'b0;
      if (cool_r != 3'h0) begin
        cool_r <= cool_r - 3'h1;
      end else if (core_in.req && take) begin
        if (wait_r >= lag) begin
          core_ack <= 1'b1;
          cool_r   <= 3'h4;
          wait_r   <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // Return and capture of the taken vector
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reti <= 1'b0;
      taken_vec <= 16'h0000;
    end else begin
      core_reti <= ret_go;
      if (core_ack) begin
        taken_vec <= core_in.vector;
      end
    end
  end
endmodule : mcuip_core_model

`default_nettype wire

// *** testbench/test_mcu_interrupt_enable_priority.sv ***
// Self-checking testbench of the interrupt controller
`timescale 1ns/10ps
`default_nettype none

module test_mcu_interrupt_enable_priority;
  // ****************************************
  // Source tables in polling order
  // ****************************************
  localparam logic [7:0]  GA [10] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h04,
                                      8'h08, 8'h10, 8'h00, 8'h20, 8'h00};
  localparam logic [7:0]  GB [10] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00,
                                      8'h00, 8'h00, 8'h10, 8'h00, 8'h20};
  localparam logic [4:0]  LV [10] = '{5'h01, 5'h00, 5'h02, 5'h00, 5'h04,
                                      5'h08, 5'h10, 5'h00, 5'h00, 5'h00};
  localparam logic [5:0]  EV [10] = '{6'h00, 6'h01, 6'h00, 6'h02, 6'h00,
                                      6'h00, 6'h00, 6'h04, 6'h10, 6'h08};
  // Timer 2 clear mask covers both of its flags
  localparam logic [7:0]  FL [10] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00,
                                      8'h00, 8'h00, 8'h10, 8'hC0, 8'h20};
  localparam logic [15:0] VEC [10] = '{16'h0003, 16'h0043, 16'h000B,
    16'h004B, 16'h0013, 16'h001B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};
  localparam int          GRP [10] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5};
  // Enable A, priority low, enable B, priority high, flags
  localparam logic [7:0]  RI [5] = '{mcuip_pkg::ENA_IDX, mcuip_pkg::PRL_IDX,
    mcuip_pkg::ENB_IDX, mcuip_pkg::PRH_IDX, mcuip_pkg::FLG_IDX};
  localparam logic [7:0]  RM [5] = '{8'hBF, 8'h3F, 8'hB3, 8'h3F, 8'hF3};

  logic                   clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic                   core_ack, core_reti, take, ret_go;
  logic [31:0]            haddr, hwdata, hrdata;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [4:0]             lvl_in, lvl_v;
  logic [3:0]             lag;
  logic [9:0]             ack_src;
  logic [15:0]            taken_vec;
  logic [7:0]             flg_exp, pl, ph;
  mcuip_pkg::mcuip_evt_t  evt;
  mcuip_pkg::mcuip_core_t core_out;
  int                     fails, comparisons, seed, e, q[$];
  logic [31:0]            d;

  mcuip_top dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .src_level_in(lvl_in), .src_evt(evt),
    .core_ack(core_ack), .core_reti(core_reti), .core_out(core_out),
    .ack_src(ack_src));

  mcuip_core_model core (.clk(clk), .rst_b(rst_b), .core_in(core_out),
    .take(take), .lag(lag), .ret_go(ret_go), .core_ack(core_ack),
    .core_reti(core_reti), .taken_vec(taken_vec));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_req(input logic exp);
    check({31'h0, core_out.req}, {31'h0, exp});
  endtask : check_req

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wait_rdy;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      fails++;
      wrap_up();
    end
  endtask : wait_rdy

  // One AHB-Lite single word transfer; read data taken at the data edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] r;
    bus(1'b1, idx, wd, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    check(r, {24'h0, exp});
    check({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  task automatic raise(input logic [9:0] m);
    logic [5:0] ev = 6'h00;
    for (int i = 0; i < 10; i++) if (m[i]) begin
      lvl_v   = lvl_v | LV[i];
      ev      = ev | EV[i];
      flg_exp = flg_exp | (FL[i] & 8'h7F);
    end
    lvl_in <= lvl_v;
    evt    <= ev;
    @(posedge clk);
    evt    <= 6'h00;
  endtask : raise

  task automatic ret;
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    tick(3);
  endtask : ret

  // Waits for a take, withdraws that source, optionally returns
  task automatic serve(input bit do_ret);
    logic [9:0] a = 10'h000;
    int         k = 0;
    do begin
      @(posedge clk);
      a = ack_src;
      k++;
    end while (a === 10'h000 && k < 300);
    if (k >= 300) begin
      fails++;
      wrap_up();
    end
    for (int i = 0; i < 10; i++) if (a[i]) begin
      if (LV[i] != 5'h00) begin
        lvl_v = lvl_v & ~LV[i];
        lvl_in <= lvl_v;
      end else begin
        flg_exp = flg_exp & ~FL[i];
        wr(RI[4], flg_exp);
      end
    end
    if (do_ret) ret();
  endtask : serve

  // ****************************************
  // Monitor: each take against the oldest note
  // ****************************************
  always @(posedge clk) begin
    if (ack_src !== 10'h000) begin
      if (q.size() == 0) check({22'h0, ack_src}, 32'h0);
      else begin
        e = q.pop_front();
        check({22'h0, ack_src}, 32'h1 << e);
        check({16'h0, taken_vec}, {16'h0, VEC[e]});
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 32'ha0437bf3;
    {rst_b, hsel, hwrite, take, ret_go} = 5'h00;
    {haddr, hwdata, htrans, lvl_in, lvl_v, lag, flg_exp} = '0;
    hsize = 3'h2;
    evt   = 6'h00;
    tick(12);
    rst_b <= 1'b1;
    tick(3);
    for (int r = 0; r < 5; r++) begin
      rd_chk(RI[r], 8'h00);
      repeat (3) begin
        d = $random(seed);
        wr(RI[r], d[7:0]);
        rd_chk(RI[r], d[7:0] & RM[r]);
      end
      wr(RI[r], 8'h00);
    end
    wr(8'hA0, 8'hFF);
    rd_chk(8'hA0, 8'h00);
    $display("test registers done");
    raise(10'h38A);
    tick(10);
    rd_chk(RI[4], 8'h73);
    wr(RI[0], 8'h3F);
    wr(RI[2], 8'h33);
    tick(3);
    check_req(1'b0);
    wr(RI[0], 8'hBF);
    tick(3);
    check_req(1'b1);
    flg_exp = 8'h00;
    wr(RI[4], 8'h00);
    $display("test flags done");
    take <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      lag <= 4'($random(seed));
      wr(RI[0], 8'hBF & ~GA[i]);
      wr(RI[2], 8'hB3 & ~GB[i]);
      raise(10'h001 << i);
      tick(4);
      check_req(1'b0);
      q.push_back(i);
      wr(RI[0], 8'h80 | GA[i]);
      wr(RI[2], GB[i]);
      serve(1'b1);
    end
    wr(RI[0], 8'hA0);
    wr(RI[2], 8'h00);
    evt <= 6'h20;
    @(posedge clk);
    evt <= 6'h00;
    flg_exp = 8'h80;
    tick(4);
    check_req(1'b0);
    q.push_back(8);
    wr(RI[2], 8'h80);
    serve(1'b1);
    $display("test gates done");
    wr(RI[0], 8'hBF);
    wr(RI[2], 8'hB3);
    for (int r = 0; r < 4; r++) begin
      take <= 1'b0;
      lag <= 4'($random(seed));
      pl = (r == 0) ? 8'h00 : 8'($random(seed)) & 8'h3F;
      ph = (r == 0) ? 8'h00 : 8'($random(seed)) & 8'h3F;
      wr(RI[1], pl);
      wr(RI[3], ph);
      raise(10'h3FF);
      for (int lv = 3; lv >= 0; lv--)
        for (int i = 0; i < 10; i++)
          if ({ph[GRP[i]], pl[GRP[i]]} == 2'(lv)) q.push_back(i);
      take <= 1'b1;
      repeat (10) serve(1'b1);
    end
    $display("test priority done");
    wr(RI[1], 8'h20);
    wr(RI[3], 8'h00);
    q.push_back(0);
    raise(10'h001);
    serve(1'b0);
    raise(10'h010);
    tick(10);
    check_req(1'b0);
    q.push_back(9);
    raise(10'h200);
    serve(1'b1);
    tick(5);
    check_req(1'b0);
    q.push_back(4);
    ret();
    serve(1'b1);
    tick(10);
    check(32'(q.size()), 32'h0);
    $display("test preemption done");
    wrap_up();
  end
endmodule : test_mcu_interrupt_enable_priority

`default_nettype wire
